/* File: hw/ccsh_top.sv */
// Common command and sync handler: decodes reset, self-test, trigger and sync commands.
// Assumes an upstream parser delivers one decoded opcode per cmd_valid/cmd_ready handshake.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_map.svh"
module ccsh_top
   import ccsh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [`CCSH_OP_W-1:0] cmd_op,
   output logic cmd_ready,
   input wire logic op_busy,
   input wire logic esr_clear,
   input wire logic [`CCSH_SET_W-1:0] comm_set_in,
   input wire logic comm_set_load,
   input wire logic backup_req,
   input wire logic selftest_fault,
   input wire logic list_en,
   input wire logic [`CCSH_CH_W-1:0] list_len,
   input wire logic [`CCSH_CH_N*`CCSH_CH_W-1:0] list_ch,
   output logic rsp_valid,
   output logic [1:0] rsp_code,
   output logic [`CCSH_ESR_W-1:0] esr,
   output logic [`CCSH_SET_W-1:0] comm_set,
   output logic [`CCSH_SET_W-1:0] work_set,
   output logic [`CCSH_SET_W-1:0] saved_set,
   output logic defaults_pending,
   output logic scan_active,
   output logic [`CCSH_CH_N-1:0] relays
);
   ccsh_state_e state_r, state_nxt;
   ccsh_op_t op_r;
   logic [`CCSH_CH_W-1:0] pos_unused;
   logic tst_done, tst_failed;
   logic scanning_w;
   logic [`CCSH_CH_N-1:0] relay_w;
   logic busy_s1_r, busy_s2_r;
   logic fault_s1_r, fault_s2_r;

   // Busy and fault come from other logic domains; two stages before use
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
         fault_s1_r <= 1'b0;
         fault_s2_r <= 1'b0;
      end else begin
         busy_s1_r <= op_busy;
         busy_s2_r <= busy_s1_r;
         fault_s1_r <= selftest_fault;
         fault_s2_r <= fault_s1_r;
      end
   end

   // Command decode in IDLE; one command at a time keeps arrival order
   wire take_w = cmd_valid && cmd_ready;
   wire is_rst_w = take_w && (cmd_op == `CCSH_OP_RST);
   wire is_tst_w = take_w && (cmd_op == `CCSH_OP_TST);
   wire is_trg_w = take_w && (cmd_op == `CCSH_OP_TRG);
   wire is_sync_w = take_w && ((cmd_op == `CCSH_OP_OPC) || (cmd_op == `CCSH_OP_OPCQ)
      || (cmd_op == `CCSH_OP_WAI));
   wire tst_refuse_w = is_tst_w && scanning_w;
   wire tst_go_w = is_tst_w && !scanning_w;
   // Triggers are still taken while a wait command holds the queue
   wire wai_trg_w = (state_r == CCSH_SYNC) && (op_r == `CCSH_OP_WAI) && cmd_valid
      && (cmd_op == `CCSH_OP_TRG);
   wire trig_w = is_trg_w || wai_trg_w;
   wire sync_done_w = (state_r == CCSH_SYNC) && !busy_s2_r;
   wire opc_set_w = sync_done_w && (op_r == `CCSH_OP_OPC);
   wire opcq_done_w = sync_done_w && (op_r == `CCSH_OP_OPCQ);

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CCSH_IDLE: begin
            if (tst_go_w)
               state_nxt = CCSH_TEST;
            else if (is_sync_w)
               state_nxt = CCSH_SYNC;
         end
         CCSH_SYNC: begin
            if (opcq_done_w)
               state_nxt = CCSH_RESP;
            else if (sync_done_w)
               state_nxt = CCSH_IDLE;
         end
         CCSH_TEST: begin
            if (tst_done)
               state_nxt = CCSH_RESP;
         end
         CCSH_RESP: state_nxt = CCSH_IDLE;
         default: state_nxt = CCSH_IDLE;
      endcase
   end

   // Ready only while idle; sync and test stall the queue
   wire ready_nxt = (state_nxt == CCSH_IDLE);
   wire wai_ack_w = wai_trg_w;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= CCSH_IDLE;
         op_r <= `CCSH_OP_OTHER;
         cmd_ready <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (take_w)
            op_r <= cmd_op;
         cmd_ready <= ready_nxt && !wai_ack_w;
      end
   end

   // Response: PASS/FAIL after the test, 1 after the query
   logic [1:0] rsp_nxt;
   assign rsp_nxt = (state_r == CCSH_TEST && tst_done) ?
      (tst_failed ? `CCSH_RSP_FAIL : `CCSH_RSP_PASS) :
      (opcq_done_w ? `CCSH_RSP_ONE : `CCSH_RSP_NONE);
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_code <= `CCSH_RSP_NONE;
      end else begin
         rsp_valid <= (rsp_nxt != `CCSH_RSP_NONE);
         rsp_code <= rsp_nxt;
      end
   end

   // Event status; a hardware set wins over the clear in the same cycle
   logic [`CCSH_ESR_W-1:0] esr_set_w;
   always_comb begin
      esr_set_w = `CCSH_ESR_RST;
      esr_set_w[`CCSH_ESR_OPC_BIT] = opc_set_w;
      esr_set_w[`CCSH_ESR_EXE_BIT] = tst_refuse_w;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         esr <= `CCSH_ESR_RST;
      else
         esr <= (esr_clear ? `CCSH_ESR_RST : esr) | esr_set_w;
   end

   // Settings: reset restores working set, comm set untouched, backup on demand
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         comm_set <= `CCSH_SET_RST;
         work_set <= `CCSH_SET_RST;
         saved_set <= `CCSH_SET_RST;
         defaults_pending <= 1'b0;
      end else begin
         if (comm_set_load)
            comm_set <= comm_set_in;
         if (is_rst_w) begin
            work_set <= `CCSH_SET_RST;
            defaults_pending <= 1'b1;
         end else if (backup_req) begin
            saved_set <= work_set;
            defaults_pending <= 1'b0;
         end
      end
   end

   // Relay and scan outputs registered here
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_active <= 1'b0;
         relays <= 16'h0000;
      end else begin
         scan_active <= scanning_w;
         relays <= relay_w;
      end
   end

   ccsh_selftest u_test (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .start(tst_go_w),
      .fault_in(fault_s2_r),
      .done(tst_done),
      .failed(tst_failed)
   );

   ccsh_scan u_scan (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .trig(trig_w),
      .open_all(is_rst_w),
      .list_en(list_en),
      .list_len(list_len),
      .list_ch(list_ch),
      .scanning(scanning_w),
      .relay_closed(relay_w),
      .scan_pos(pos_unused)
   );

   // Checks
   sequence s_sync_wait;
      state_r == CCSH_SYNC && busy_s2_r;
   endsequence
   property p_refuse_exe;
      @(posedge ref_clk) disable iff (!reset_n)
      tst_refuse_w |=> esr[`CCSH_ESR_EXE_BIT];
   endproperty
   a_refuse_exe: assert property (p_refuse_exe) else $error("exe bit not set");
   property p_refuse_notest;
      @(posedge ref_clk) disable iff (!reset_n)
      tst_refuse_w |=> state_r == CCSH_IDLE;
   endproperty
   a_refuse_notest: assert property (p_refuse_notest) else $error("test ran in scan");
   property p_hold_ready;
      @(posedge ref_clk) disable iff (!reset_n)
      s_sync_wait |=> !cmd_ready;
   endproperty
   a_hold_ready: assert property (p_hold_ready) else $error("ready during sync");
   property p_opcq_one;
      @(posedge ref_clk) disable iff (!reset_n)
      opcq_done_w |=> rsp_valid && rsp_code == `CCSH_RSP_ONE;
   endproperty
   a_opcq_one: assert property (p_opcq_one) else $error("no 1 reply");
   property p_opc_set;
      @(posedge ref_clk) disable iff (!reset_n)
      opc_set_w |=> esr[`CCSH_ESR_OPC_BIT];
   endproperty
   a_opc_set: assert property (p_opc_set) else $error("opc bit not set");
   property p_wai_quiet;
      @(posedge ref_clk) disable iff (!reset_n)
      (sync_done_w && op_r == `CCSH_OP_WAI && !esr[`CCSH_ESR_OPC_BIT] && !esr_clear)
      |=> !esr[`CCSH_ESR_OPC_BIT];
   endproperty
   a_wai_quiet: assert property (p_wai_quiet) else $error("wait set opc");
   property p_rst_open;
      @(posedge ref_clk) disable iff (!reset_n)
      is_rst_w |=> ##1 relays == 16'h0000 && !scan_active;
   endproperty
   a_rst_open: assert property (p_rst_open) else $error("relay left closed");
   property p_tst_reply;
      @(posedge ref_clk) disable iff (!reset_n)
      tst_go_w |-> ##[17:20] rsp_valid && rsp_code != `CCSH_RSP_ONE;
   endproperty
   a_tst_reply: assert property (p_tst_reply) else $error("no self-test reply");
   property p_comm_keep;
      @(posedge ref_clk) disable iff (!reset_n)
      (is_rst_w && !comm_set_load) |=> $stable(comm_set);
   endproperty
   a_comm_keep: assert property (p_comm_keep) else $error("comm set changed");
endmodule
`default_nettype wire

/* File: inc/ccsh_map.svh */
// Constants for the common command and sync handler: opcodes, field positions, tokens.
// Included by the package and the design modules; definitions only.
`ifndef CCSH_MAP_SVH
`define CCSH_MAP_SVH
`define CCSH_OP_W 3
`define CCSH_OP_RST 3'h0
`define CCSH_OP_TST 3'h1
`define CCSH_OP_TRG 3'h2
`define CCSH_OP_OPC 3'h3
`define CCSH_OP_OPCQ 3'h4
`define CCSH_OP_WAI 3'h5
`define CCSH_OP_OTHER 3'h6
`define CCSH_ESR_W 8
`define CCSH_ESR_OPC_BIT 0
`define CCSH_ESR_EXE_BIT 4
`define CCSH_ESR_RST 8'h00
`define CCSH_CH_N 16
`define CCSH_CH_W 4
`define CCSH_RSP_PASS 2'h1
`define CCSH_RSP_FAIL 2'h2
`define CCSH_RSP_ONE 2'h3
`define CCSH_RSP_NONE 2'h0
`define CCSH_TST_CYC 8'h10
`define CCSH_SET_W 16
`define CCSH_SET_RST 16'h0000
`endif

/* File: inc/ccsh_pkg.sv */
// Types for the common command and sync handler.
// Assumes ccsh_map.svh is on the include path.
`include "ccsh_map.svh"
package ccsh_pkg;
   typedef logic [`CCSH_OP_W-1:0] ccsh_op_t;
   typedef logic [1:0] ccsh_rsp_t;
   typedef enum logic [2:0] {
      CCSH_IDLE = 3'h0,
      CCSH_EXEC = 3'h1,
      CCSH_SYNC = 3'h3,
      CCSH_TEST = 3'h2,
      CCSH_RESP = 3'h6
   } ccsh_state_e;
endpackage

/* File: hw/ccsh_selftest.sv */
// Self-test sequencer: runs a fixed-length internal check and reports pass or fail.
// Assumes start is a one-cycle pulse; fault_in is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_map.svh"
module ccsh_selftest
   import ccsh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic fault_in,
   output logic done,
   output logic failed
);
   logic [7:0] cnt_r;
   logic busy_r;
   logic err_r;
   wire last_w = busy_r && (cnt_r == `CCSH_TST_CYC);
   // Count test cycles, accumulate any fault seen while busy
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 8'h00;
         busy_r <= 1'b0;
         err_r <= 1'b0;
         done <= 1'b0;
         failed <= 1'b0;
      end else begin
         done <= last_w;
         if (start) begin
            busy_r <= 1'b1;
            cnt_r <= 8'h01;
            err_r <= 1'b0;
         end else if (last_w) begin
            busy_r <= 1'b0;
            failed <= err_r | fault_in;
         end else if (busy_r) begin
            cnt_r <= cnt_r + 8'h01;
            err_r <= err_r | fault_in;
         end
      end
   end
endmodule
`default_nettype wire

/* File: hw/ccsh_scan.sv */
// Scan stepper: walks the registered scan list and owns the relay closure state.
// Assumes list entries arrive through list_ch and list_len, steady while scanning.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_map.svh"
module ccsh_scan
   import ccsh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic trig,
   input wire logic open_all,
   input wire logic list_en,
   input wire logic [`CCSH_CH_W-1:0] list_len,
   input wire logic [`CCSH_CH_N*`CCSH_CH_W-1:0] list_ch,
   output logic scanning,
   output logic [`CCSH_CH_N-1:0] relay_closed,
   output logic [`CCSH_CH_W-1:0] scan_pos
);
   logic [`CCSH_CH_W-1:0] ch_sel_w [`CCSH_CH_N];
   logic [`CCSH_CH_N-1:0] onehot_w;
   genvar gi;
   // Unpack the list into entries
   generate
      for (gi = 0; gi < `CCSH_CH_N; gi++) begin : g_ent
         assign ch_sel_w[gi] = list_ch[gi*`CCSH_CH_W +: `CCSH_CH_W];
      end
   endgenerate
   wire [`CCSH_CH_W-1:0] pos_nxt = scanning ? scan_pos + 4'h1 : 4'h0;
   wire at_end_w = scanning && (scan_pos == list_len);
   assign onehot_w = `CCSH_CH_N'(1) << ch_sel_w[pos_nxt];
   // Trigger starts or advances; last entry ends the scan
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scanning <= 1'b0;
         scan_pos <= 4'h0;
         relay_closed <= 16'h0000;
      end else if (open_all) begin
         scanning <= 1'b0;
         scan_pos <= 4'h0;
         relay_closed <= 16'h0000;
      end else if (trig && at_end_w) begin
         scanning <= 1'b0;
         relay_closed <= 16'h0000;
      end else if (trig && (scanning || list_en)) begin
         scanning <= 1'b1;
         scan_pos <= pos_nxt;
         relay_closed <= onehot_w;
      end
   end
endmodule
`default_nettype wire

/* File: tb/ccsh_host_model.sv */
// Host model: offers one decoded command at a time over valid/ready.
// Assumes the bench calls issue from one process, one command after another.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_map.svh"
module ccsh_host_model
   import ccsh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output logic [`CCSH_OP_W-1:0] cmd_op
);
   initial begin
      cmd_valid = 1'h0;
      cmd_op = 3'h7;
   end
   // Request held until taken; a trigger inside a wait is taken unasked
   task automatic issue(input logic [`CCSH_OP_W-1:0] op, input bit unasked, output bit ok);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd_valid <= 1'h1;
      cmd_op <= op;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!cmd_ready && !unasked && n < 400);
      ok = cmd_ready || unasked;
      cmd_valid <= 1'h0;
      // Released opcode lines never show the last command
      cmd_op <= ~op;
   endtask
endmodule
`default_nettype wire

/* File: tb/ccsh_tb_top.sv */
// Bench for the command and sync handler, with a scan model kept in integers.
// Assumes the design and host model files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_map.svh"
module ccsh_tb_top;
   import ccsh_pkg::*;
   logic ref_clk, reset_n, cmd_valid, cmd_ready, op_busy, esr_clear;
   logic comm_set_load, backup_req, selftest_fault, list_en, rsp_valid;
   logic defaults_pending, scan_active;
   logic [`CCSH_OP_W-1:0] cmd_op;
   logic [`CCSH_SET_W-1:0] comm_set_in, comm_set, work_set, saved_set;
   logic [`CCSH_CH_W-1:0] list_len;
   logic [`CCSH_CH_N*`CCSH_CH_W-1:0] list_ch;
   logic [1:0] rsp_code;
   logic [`CCSH_ESR_W-1:0] esr;
   logic [`CCSH_CH_N-1:0] relays;
   logic [3:0] ch [16];
   logic [15:0] cval;
   int num_errors, num_checks, seed, mscan, mpos, i, n;

   ccsh_host_model ccsh_host_model_inst (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op));
   ccsh_top ccsh_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_ready(cmd_ready), .op_busy(op_busy), .esr_clear(esr_clear),
      .comm_set_in(comm_set_in), .comm_set_load(comm_set_load), .backup_req(backup_req),
      .selftest_fault(selftest_fault), .list_en(list_en), .list_len(list_len),
      .list_ch(list_ch), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .esr(esr),
      .comm_set(comm_set), .work_set(work_set), .saved_set(saved_set),
      .defaults_pending(defaults_pending), .scan_active(scan_active), .relays(relays));

   // 200 MHz
   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic send(input logic [2:0] op, input bit unasked);
      bit ok;
      ccsh_host_model_inst.issue(op, unasked, ok);
      if (!ok) begin
         num_errors++;
         close_out();
      end
   endtask

   // Answer is read at the edge where the one-cycle strobe is seen
   task automatic wait_rsp(input logic [1:0] exp);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (rsp_valid !== 1'h1 && n < 100);
      // Judge by the strobe itself, so a reply on the last allowed edge still counts
      if (rsp_valid !== 1'h1) begin
         num_errors++;
         close_out();
      end
      check("rsp_code", rsp_code, exp);
   endtask

   task automatic pulse_clear();
      esr_clear <= 1'h1;
      @(posedge ref_clk);
      esr_clear <= 1'h0;
      @(posedge ref_clk);
   endtask

   // Scan model: start at entry 0, step, stop after the last entry
   task automatic trg_model(input bit unasked);
      send(`CCSH_OP_TRG, unasked);
      // A trigger with the list disabled and no scan running does nothing
      if (mscan == 0) begin
         if (list_en) begin
            mscan = 1;
            mpos = 0;
         end
      end else if (mpos == 2)
         mscan = 0;
      else
         mpos++;
      repeat (3) @(posedge ref_clk);
      check("scan_active", scan_active, mscan[0]);
      check("relays", relays, mscan ? 16'h0001 << ch[mpos] : 16'h0000);
   endtask

   // Main sequence
   initial begin
      seed = 58;
      mscan = 0;
      mpos = 0;
      reset_n <= 1'h0;
      op_busy <= 1'h0;
      esr_clear <= 1'h0;
      comm_set_in <= 16'h0000;
      comm_set_load <= 1'h0;
      backup_req <= 1'h0;
      selftest_fault <= 1'h0;
      list_en <= 1'h1;
      list_len <= 4'h2;
      for (i = 0; i < 16; i++) begin
         ch[i] = 4'($random(seed));
         list_ch[4*i +: 4] <= ch[i];
      end
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge ref_clk);
      check("cmd_ready", cmd_ready, 1'h1);
      check("defaults_pending", defaults_pending, 1'h0);
      for (i = 0; i < 2; i++) begin
         selftest_fault <= i[0];
         repeat (4) @(posedge ref_clk);
         send(`CCSH_OP_TST, 1'h0);
         wait_rsp(i ? `CCSH_RSP_FAIL : `CCSH_RSP_PASS);
      end
      $display("test selftest done");
      for (i = 0; i < 5; i++)
         trg_model(1'h0);
      send(`CCSH_OP_TST, 1'h0);
      n = 0;
      repeat (40) begin
         @(posedge ref_clk);
         n += int'(rsp_valid === 1'h1);
      end
      check("refused_rsp", n, 0);
      check("esr_exe", esr[`CCSH_ESR_EXE_BIT], 1'h1);
      $display("test scan done");
      cval = 16'($random(seed));
      comm_set_in <= cval;
      comm_set_load <= 1'h1;
      @(posedge ref_clk);
      comm_set_load <= 1'h0;
      send(`CCSH_OP_RST, 1'h0);
      mscan = 0;
      repeat (3) @(posedge ref_clk);
      check("relays", relays, 16'h0000);
      check("scan_active", scan_active, 1'h0);
      check("work_set", work_set, `CCSH_SET_RST);
      check("comm_set", comm_set, cval);
      check("defaults_pending", defaults_pending, 1'h1);
      // Disabled list: a trigger must not start a scan
      list_en <= 1'h0;
      trg_model(1'h0);
      list_en <= 1'h1;
      backup_req <= 1'h1;
      @(posedge ref_clk);
      backup_req <= 1'h0;
      repeat (2) @(posedge ref_clk);
      check("defaults_pending", defaults_pending, 1'h0);
      check("saved_set", saved_set, `CCSH_SET_RST);
      $display("test reset done");
      pulse_clear();
      op_busy <= 1'h1;
      repeat (4) @(posedge ref_clk);
      send(`CCSH_OP_OPC, 1'h0);
      repeat (8) @(posedge ref_clk);
      check("cmd_ready", cmd_ready, 1'h0);
      check("esr_opc", esr[`CCSH_ESR_OPC_BIT], 1'h0);
      op_busy <= 1'h0;
      repeat (8) @(posedge ref_clk);
      check("esr", esr, 8'h01);
      op_busy <= 1'h1;
      repeat (4) @(posedge ref_clk);
      send(`CCSH_OP_OPCQ, 1'h0);
      repeat (6) @(posedge ref_clk);
      op_busy <= 1'h0;
      wait_rsp(`CCSH_RSP_ONE);
      $display("test opc done");
      pulse_clear();
      op_busy <= 1'h1;
      repeat (4) @(posedge ref_clk);
      send(`CCSH_OP_WAI, 1'h0);
      repeat (2) @(posedge ref_clk);
      trg_model(1'h1);
      check("cmd_ready", cmd_ready, 1'h0);
      op_busy <= 1'h0;
      repeat (8) @(posedge ref_clk);
      check("esr", esr, 8'h00);
      check("cmd_ready", cmd_ready, 1'h1);
      $display("test wait done");
      close_out();
   end
endmodule
`default_nettype wire
